// ===== include/pnp_pkg.sv
// constants for the partner next page status register and its management frame
package pnp_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [4:0] PARTNER_NEXT_PAGE_OFFSET = 5'h08;
    localparam logic [15:0] PARTNER_NEXT_PAGE_RESET = 16'h0000;
    localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h00;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int MORE_PAGES_POS = 15;
    localparam int ACK_POS = 14;
    localparam int MSG_PAGE_POS = 13;
    localparam int ACK2_POS = 12;
    localparam int TOGGLE_POS = 11;
    localparam int CODE_MSB = 10;
    localparam int CODE_LSB = 0;
    // ----------------------------------------
    // frame layout
    // ----------------------------------------
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [4:0] HDR_LEN = 5'h0d;
    localparam logic [4:0] DATA_LEN = 5'h10;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
endpackage

// ===== src/pnp_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pnp_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== src/partner_next_page_status.sv
// partner next page status register with its management serial slave
`timescale 1ns/1ps
`default_nettype none
module partner_next_page_status #(
    parameter logic [4:0] PHY_ADDR = pnp_pkg::PHY_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // management pins
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    // received page from arbitration
    input wire logic page_valid_i,
    input wire logic [15:0] page_word_i,
    // status
    output logic toggle_error_o,
    output logic [15:0] page_o
);
    // ----------------------------------------
    // page holding register
    // ----------------------------------------
    logic [15:0] page;
    logic seen_page;
    wire toggle_bad = seen_page &&
        (page_word_i[pnp_pkg::TOGGLE_POS] == page[pnp_pkg::TOGGLE_POS]);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page <= pnp_pkg::PARTNER_NEXT_PAGE_RESET;
            seen_page <= 1'b0;
            toggle_error_o <= 1'b0;
        end else begin
            toggle_error_o <= page_valid_i && toggle_bad;
            if (page_valid_i) begin
                page <= page_word_i;
                seen_page <= 1'b1;
            end
        end
    end

    // field view of the stored page
    wire more_pages = page[pnp_pkg::MORE_PAGES_POS];
    wire partner_ack = page[pnp_pkg::ACK_POS];
    wire message_page = page[pnp_pkg::MSG_PAGE_POS];
    wire partner_ack2 = page[pnp_pkg::ACK2_POS];
    wire partner_toggle = page[pnp_pkg::TOGGLE_POS];
    wire [10:0] code_field = page[pnp_pkg::CODE_MSB:pnp_pkg::CODE_LSB];
    wire [15:0] read_word = {more_pages, partner_ack, message_page, partner_ack2,
                             partner_toggle, code_field};

    assign page_o = page;

    // ----------------------------------------
    // pin synchronisation and clock edge
    // ----------------------------------------
    logic [1:0] pins_sync;
    logic mdc_last;

    pnp_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i({mdc_i, mdio_i}),
        .sync_o(pins_sync)
    );

    wire mdc_s = pins_sync[1];
    wire mdio_s = pins_sync[0];
    wire mdc_rise = mdc_s && !mdc_last;

    // ----------------------------------------
    // frame state machine
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HDR,
        ST_TA,
        ST_DATA
    } frame_e;

    frame_e state;
    frame_e next_state;
    logic [5:0] ones;
    logic [4:0] bit_cnt;
    logic [12:0] hdr;
    logic [15:0] shift;
    logic reading;

    // header holds second start bit, opcode, phy address, register address
    wire [12:0] hdr_full = {hdr[11:0], mdio_s};
    wire hdr_done = (bit_cnt == pnp_pkg::HDR_LEN - 5'h01);
    wire start_ok = hdr_full[12];
    wire [1:0] opcode = hdr_full[11:10];
    wire addr_hit = (hdr_full[9:5] == PHY_ADDR) &&
                    (hdr_full[4:0] == pnp_pkg::PARTNER_NEXT_PAGE_OFFSET);
    wire is_read = start_ok && (opcode == pnp_pkg::OP_READ) && addr_hit;
    wire is_write = start_ok && (opcode == pnp_pkg::OP_WRITE);
    wire ta_done = (bit_cnt == 5'h01);
    wire data_done = (bit_cnt == pnp_pkg::DATA_LEN - 5'h01);
    wire preamble_ok = (ones == pnp_pkg::PREAMBLE_LEN);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (mdc_rise && !mdio_s && preamble_ok) begin
                    next_state = ST_HDR;
                end
            end
            ST_HDR: begin
                if (mdc_rise && hdr_done) begin
                    next_state = (is_read || is_write) ? ST_TA : ST_IDLE;
                end
            end
            ST_TA: begin
                if (mdc_rise && ta_done) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (mdc_rise && data_done) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdc_last <= 1'b0;
            state <= ST_IDLE;
        end else begin
            mdc_last <= mdc_s;
            state <= next_state;
        end
    end

    // bit counter restarts on every state change
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt <= 5'h00;
        end else if (mdc_rise) begin
            if (state != next_state) begin
                bit_cnt <= 5'h00;
            end else begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // preamble ones, saturating at the required run
    wire ones_inc = (state == ST_IDLE) && mdio_s && !preamble_ok;
    wire ones_clr = (state != ST_IDLE) || !mdio_s;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ones <= 6'h00;
        end else if (mdc_rise) begin
            if (ones_inc) begin
                ones <= ones + 6'h01;
            end else if (ones_clr) begin
                ones <= 6'h00;
            end
        end
    end

    // header capture and read decision
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hdr <= 13'h0000;
            reading <= 1'b0;
        end else if (mdc_rise && state == ST_HDR) begin
            hdr <= hdr_full;
            if (hdr_done) begin
                reading <= is_read; // writes never drive or store
            end
        end
    end

    // ----------------------------------------
    // read data output
    // ----------------------------------------
    // shift register advance, one bit per mdc rise
    function automatic logic [15:0] next_shift(input logic [15:0] s);
        return {s[14:0], 1'b0};
    endfunction

    wire load_word = (state == ST_HDR) && hdr_done;
    wire drive_turn = (state == ST_TA) && !ta_done && reading;
    wire drive_first = (state == ST_TA) && ta_done && reading;
    wire drive_rest = (state == ST_DATA) && !data_done && reading;
    wire drive_bit = drive_first || drive_rest;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdio_o <= 1'b1;
            mdio_oe_o <= 1'b0;
            shift <= 16'h0000;
        end else if (mdc_rise) begin
            if (load_word) begin
                mdio_oe_o <= 1'b0;
                shift <= read_word;
            end else if (drive_turn) begin
                mdio_oe_o <= 1'b1;
                mdio_o <= 1'b0;
            end else if (drive_bit) begin
                mdio_o <= shift[15];
                shift <= next_shift(shift);
            end else begin
                mdio_oe_o <= 1'b0;
                mdio_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/partner_next_page_status_chk.sv
// checker on the partner next page status ports
`timescale 1ns/1ps
`default_nettype none
module partner_next_page_status_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pins and page
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_o,
    input wire logic page_valid_i,
    input wire logic [15:0] page_word_i,
    input wire logic toggle_error_o,
    input wire logic [15:0] page_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_more_pages: assert property (page_valid_i |=> page_o[15] == $past(page_word_i[15]))
        else $error("more pages bit wrong");
    a_ack_flag: assert property (page_valid_i |=> page_o[14] == $past(page_word_i[14]))
        else $error("ack bit wrong");
    a_page_type: assert property (page_valid_i |=> page_o[13] == $past(page_word_i[13]))
        else $error("page type bit wrong");
    a_comply_ack: assert property (page_valid_i |=> page_o[12] == $past(page_word_i[12]))
        else $error("comply bit wrong");
    a_toggle_ok: assert property (page_valid_i && page_word_i[11] != page_o[11] |=> !toggle_error_o)
        else $error("false toggle error");
    a_code_field: assert property (page_valid_i |=> page_o[10:0] == $past(page_word_i[10:0]))
        else $error("code field wrong");
    a_reset_zero: assert property (@(posedge clk_i) disable iff (1'b0) !rst_n_i |-> page_o == 16'h0000)
        else $error("register not zero in reset");
    a_page_hold: assert property (!page_valid_i |=> $stable(page_o))
        else $error("register changed without page");
endmodule
`default_nettype wire

// ===== tb/partner_next_page_status_tb_top.sv
// self-checking bench for the partner next page status register
`timescale 1ns/1ps
`default_nettype none
module partner_next_page_status_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic mdc_i = 1'b0;
    logic mdio_i = 1'b1;
    logic page_valid_i = 1'b0;
    logic [15:0] page_word_i = 16'h0000;
    logic mdio_o, mdio_oe_o, toggle_error_o;
    logic [15:0] page_o;
    logic [17:0] rd;
    int err_total = 0;
    int compares = 0;
    partner_next_page_status i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mdc_i(mdc_i), .mdio_i(mdio_i),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .page_valid_i(page_valid_i), .page_word_i(page_word_i),
        .toggle_error_o(toggle_error_o), .page_o(page_o));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one mdc period, pin sampled just before the rise
    task automatic mbit(input logic b, output logic r, output logic oe);
        mdc_i = 1'b0;
        mdio_i = b;
        cyc(5);
        r = mdio_o;
        oe = mdio_oe_o;
        mdc_i = 1'b1;
        cyc(5);
    endtask
    // whole frame; result is {oe, turnaround, 16 data bits}
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [17:0] q);
        logic r, o;
        logic [45:0] hdr;
        logic [17:0] wf;
        hdr = {32'hffffffff, 2'b01, op, pnp_pkg::PHY_ADDR_DEFAULT, ra};
        wf = {2'b10, wd};
        q = 18'h00000;
        for (int i = 45; i >= 0; i--) mbit(hdr[i], r, o);
        for (int i = 0; i < 19; i++) begin
            mbit((op == pnp_pkg::OP_WRITE && i < 18) ? wf[17 - i] : 1'b1, r, o);
            if (i == 2) q[17] = o;
            if (i >= 1 && i <= 17) q[16:0] = {q[15:0], r};
        end
    endtask
    task automatic t_reset();
        chk(page_o, 16'h0000);
        frame(pnp_pkg::OP_READ, 5'h08, 16'h0000, rd);
        chk(rd, 18'h20000);
        chk(mdio_oe_o, 1'b0);
    endtask
    task automatic t_pages();
        logic [15:0] w [3] = '{16'ha801, 16'h4fff, 16'h3000};
        logic e [3] = '{1'b0, 1'b1, 1'b0};
        for (int k = 0; k < 3; k++) begin
            page_valid_i = 1'b1;
            page_word_i = w[k];
            cyc(1);
            chk(page_o, w[k]);
            chk(toggle_error_o, e[k]);
        end
        page_valid_i = 1'b0;
        cyc(2);
        chk(page_o, 16'h3000);
        frame(pnp_pkg::OP_READ, 5'h08, 16'h0000, rd);
        chk(rd, 18'h23000);
    endtask
    task automatic t_write();
        frame(pnp_pkg::OP_WRITE, 5'h08, 16'hffff, rd);
        chk(rd, 18'h1ffff);
        frame(pnp_pkg::OP_READ, 5'h09, 16'h0000, rd);
        chk(rd, 18'h1ffff);
        frame(pnp_pkg::OP_READ, 5'h08, 16'h0000, rd);
        chk(rd, 18'h23000);
    endtask
    task automatic t_rerun();
        rst_n_i = 1'b0;
        cyc(2);
        chk(page_o, 16'h0000);
        rst_n_i = 1'b1;
        cyc(3);
        page_valid_i = 1'b1;
        page_word_i = 16'h2005;
        cyc(1);
        page_valid_i = 1'b0;
        chk(toggle_error_o, 1'b0);
        chk(page_o, 16'h2005);
        frame(pnp_pkg::OP_READ, 5'h08, 16'h0000, rd);
        chk(rd, 18'h22005);
        chk(mdio_oe_o, 1'b0);
    endtask
    initial begin
        #1;
        rst_n_i = 1'b0;
        cyc(12);
        rst_n_i = 1'b1;
        cyc(3);
        t_reset();
        t_pages();
        t_write();
        t_rerun();
        conclude();
    end
    initial begin
        #100000;
        err_total++;
        conclude();
    end
endmodule
bind partner_next_page_status partner_next_page_status_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .page_valid_i(page_valid_i),
    .page_word_i(page_word_i), .toggle_error_o(toggle_error_o), .page_o(page_o));
`default_nettype wire
